// file: rtl/prox_readback_reset_regs.sv
// Purpose: phase readback, offset override, threshold readback, soft reset and identity regs
// Assumes: one register request per cycle from the serial host engine, synchronous to core_clk
// Notes:   read data answers one cycle after the request; unmapped reads return zero
`timescale 1ns/1ps
module prox_readback_reset_regs
#(
  parameter int         PHASES        = prox_regs_pkg::NUM_PHASES,
  parameter logic [7:0] PART_CODE     = 8'h5A, // arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h01  // arbitrary value
)
(
  input  wire logic                                    core_clk,
  input  wire logic                                    rst,
  input  wire prox_regs_pkg::reg_req_t                 reg_req,
  output prox_regs_pkg::reg_rsp_t                      reg_rsp_reg,
  input  wire prox_regs_pkg::phase_data_t              phase_data [PHASES],
  input  wire logic                                    cal_valid,
  input  wire logic [prox_regs_pkg::PHASE_SEL_W-1:0]   cal_phase,
  input  wire logic [prox_regs_pkg::OFFSET_W-1:0]      cal_offset,
  input  wire logic [7:0]                              threshold_slope,
  input  wire logic signed [prox_regs_pkg::DATA_W-1:0] third_phase_sample,
  input  wire logic signed [prox_regs_pkg::DATA_W-1:0] threshold_bias,
  output logic [prox_regs_pkg::OFFSET_W-1:0]           comp_offset_reg [PHASES],
  output logic [prox_regs_pkg::PHASE_SEL_W-1:0]        readback_phase_select_reg,
  output logic                                         soft_reset_req_reg
);

  if (PHASES != prox_regs_pkg::NUM_PHASES)
    $error("PHASES must equal the selector range");

  logic                                       blk_rst;
  logic                                       wr_phase_sel;
  logic                                       wr_comp_hi;
  logic                                       wr_comp_lo;
  logic                                       wr_reset_key;
  logic [prox_regs_pkg::COMP_HI_W-1:0]        pending_hi_reg;
  logic                                       pending_valid_reg;
  logic signed [prox_regs_pkg::DATA_W-1:0]    threshold_val;
  logic [prox_regs_pkg::OFFSET_W-1:0]         sel_offset;
  prox_regs_pkg::phase_data_t                 sel_data;
  prox_regs_pkg::reg_rsp_t                    reg_rsp_next;

  // soft reset clears this bank the cycle after the key lands
  assign blk_rst      = rst | soft_reset_req_reg;
  assign wr_phase_sel = reg_req.wr && (reg_req.addr == prox_regs_pkg::ADDR_PHASE_SEL);
  assign wr_comp_hi   = reg_req.wr && (reg_req.addr == prox_regs_pkg::ADDR_COMP_HI);
  assign wr_comp_lo   = reg_req.wr && (reg_req.addr == prox_regs_pkg::ADDR_COMP_LO);
  assign wr_reset_key = reg_req.wr && (reg_req.addr == prox_regs_pkg::ADDR_SOFT_RST)
                        && (reg_req.wdata == prox_regs_pkg::RESET_KEY);
  assign sel_data     = phase_data[readback_phase_select_reg];
  assign sel_offset   = comp_offset_reg[readback_phase_select_reg];

  prox_threshold_calc u_threshold
  (
    .core_clk           (core_clk),
    .rst                (blk_rst),
    .threshold_slope    (threshold_slope),
    .third_phase_sample (third_phase_sample),
    .threshold_bias     (threshold_bias),
    .threshold_reg      (threshold_val)
  );

  always_ff @(posedge core_clk)
  begin
    if (blk_rst)
      readback_phase_select_reg <= prox_regs_pkg::PHASE_SEL_RST;
    else if (wr_phase_sel)
      readback_phase_select_reg <= reg_req.wdata[prox_regs_pkg::PHASE_SEL_W-1:0];
  end

  // only the exact key triggers; the request itself is not reset by itself
  always_ff @(posedge core_clk)
  begin
    if (rst)
      soft_reset_req_reg <= 1'b0;
    else
      soft_reset_req_reg <= wr_reset_key && !soft_reset_req_reg;
  end

  always_ff @(posedge core_clk)
  begin
    if (blk_rst)
    begin
      pending_hi_reg    <= prox_regs_pkg::COMP_HI_RST;
      pending_valid_reg <= 1'b0;
    end
    else if (wr_comp_hi)
    begin
      pending_hi_reg    <= reg_req.wdata[prox_regs_pkg::COMP_HI_W-1:0];
      pending_valid_reg <= 1'b1;
    end
    else if (wr_comp_lo)
      pending_valid_reg <= 1'b0;
  end

  // host override is written after the calibration update so it wins a collision
  always_ff @(posedge core_clk)
  begin
    if (blk_rst)
    begin
      for (int i = 0; i < PHASES; i++)
        comp_offset_reg[i] <= prox_regs_pkg::OFFSET_RST;
    end
    else
    begin
      if (cal_valid)
        comp_offset_reg[cal_phase] <= cal_offset;
      if (wr_comp_lo && pending_valid_reg)
        comp_offset_reg[readback_phase_select_reg] <= {pending_hi_reg, reg_req.wdata};
      else if (wr_comp_lo)
        comp_offset_reg[readback_phase_select_reg][7:0] <= reg_req.wdata;
    end
  end

  always_comb
  begin
    reg_rsp_next.valid = reg_req.rd;
    reg_rsp_next.rdata = prox_regs_pkg::READ_ZERO;
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        prox_regs_pkg::ADDR_PHASE_SEL:
          reg_rsp_next.rdata = {6'h00, readback_phase_select_reg};
        prox_regs_pkg::ADDR_USE_HI:  reg_rsp_next.rdata = prox_regs_pkg::hi_byte(sel_data.useful);
        prox_regs_pkg::ADDR_USE_LO:  reg_rsp_next.rdata = prox_regs_pkg::lo_byte(sel_data.useful);
        prox_regs_pkg::ADDR_AVG_HI:  reg_rsp_next.rdata = prox_regs_pkg::hi_byte(sel_data.avg);
        prox_regs_pkg::ADDR_AVG_LO:  reg_rsp_next.rdata = prox_regs_pkg::lo_byte(sel_data.avg);
        prox_regs_pkg::ADDR_DIFF_HI: reg_rsp_next.rdata = prox_regs_pkg::hi_byte(sel_data.diff);
        prox_regs_pkg::ADDR_COMP_HI:
          reg_rsp_next.rdata = {prox_regs_pkg::COMP_HI_PAD, sel_offset[13:8]};
        prox_regs_pkg::ADDR_COMP_LO: reg_rsp_next.rdata = sel_offset[7:0];
        prox_regs_pkg::ADDR_THR_HI:
          reg_rsp_next.rdata = prox_regs_pkg::hi_byte(threshold_val);
        prox_regs_pkg::ADDR_THR_LO:
          reg_rsp_next.rdata = prox_regs_pkg::lo_byte(threshold_val);
        prox_regs_pkg::ADDR_SOFT_RST: reg_rsp_next.rdata = prox_regs_pkg::READ_ZERO;
        prox_regs_pkg::ADDR_CHIP_ID:  reg_rsp_next.rdata = PART_CODE;
        prox_regs_pkg::ADDR_REV:      reg_rsp_next.rdata = REVISION_CODE;
        default:                      reg_rsp_next.rdata = prox_regs_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (blk_rst)
      reg_rsp_reg <= '0;
    else
      reg_rsp_reg <= reg_rsp_next;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || soft_reset_req_reg);

  property p_lo_commits_pending;
    wr_comp_lo && pending_valid_reg |=>
      comp_offset_reg[$past(readback_phase_select_reg)]
        == {$past(pending_hi_reg), $past(reg_req.wdata)};
  endproperty
  a_lo_commits_pending: assert property (p_lo_commits_pending)
    else $error("offset not committed on lower byte write");

  property p_hi_write_deferred;
    wr_comp_hi && !cal_valid |=> $stable(comp_offset_reg[readback_phase_select_reg])
      && pending_valid_reg;
  endproperty
  a_hi_write_deferred: assert property (p_hi_write_deferred)
    else $error("upper byte write changed active offset");

  property p_lo_alone;
    wr_comp_lo && !pending_valid_reg && !cal_valid |=>
      $stable(comp_offset_reg[readback_phase_select_reg][13:8])
      && comp_offset_reg[readback_phase_select_reg][7:0] == $past(reg_req.wdata);
  endproperty
  a_lo_alone: assert property (p_lo_alone)
    else $error("lower byte write disturbed upper bits");

  property p_comp_hi_read;
    reg_req.rd && reg_req.addr == prox_regs_pkg::ADDR_COMP_HI |=> reg_rsp_reg.valid
      && reg_rsp_reg.rdata == {prox_regs_pkg::COMP_HI_PAD, $past(sel_offset[13:8])};
  endproperty
  a_comp_hi_read: assert property (p_comp_hi_read)
    else $error("offset upper readback wrong");

  property p_thr_read;
    reg_req.rd && reg_req.addr == prox_regs_pkg::ADDR_THR_HI |=>
      reg_rsp_reg.rdata == $past(threshold_val[15:8]);
  endproperty
  a_thr_read: assert property (p_thr_read)
    else $error("threshold upper byte readback wrong");

  // a key landing in the pulse cycle itself is lost, so only idle cycles are checked
  property p_key_resets;
    wr_reset_key && !soft_reset_req_reg |=> soft_reset_req_reg;
  endproperty
  a_key_resets: assert property (@(posedge core_clk) disable iff (rst) p_key_resets)
    else $error("reset key did not raise soft reset");

  property p_reset_reads_zero;
    reg_req.rd && reg_req.addr == prox_regs_pkg::ADDR_SOFT_RST |=> reg_rsp_reg.rdata == 8'h00;
  endproperty
  a_reset_reads_zero: assert property (p_reset_reads_zero)
    else $error("soft reset register read nonzero");

  property p_phase_sel_write;
    wr_phase_sel |=> readback_phase_select_reg == $past(reg_req.wdata[1:0]);
  endproperty
  a_phase_sel_write: assert property (p_phase_sel_write)
    else $error("phase selector not written");

  property p_id_fixed;
    reg_req.rd && reg_req.addr == prox_regs_pkg::ADDR_CHIP_ID |=>
      reg_rsp_reg.valid && reg_rsp_reg.rdata == PART_CODE;
  endproperty
  a_id_fixed: assert property (p_id_fixed)
    else $error("identity code readback wrong");

  property p_cov_override;
    wr_comp_hi ##[1:20] wr_comp_lo;
  endproperty
  c_cov_override: cover property (p_cov_override);

  property p_cov_soft_reset;
    wr_reset_key ##1 soft_reset_req_reg;
  endproperty
  c_cov_soft_reset: cover property (@(posedge core_clk) disable iff (rst) p_cov_soft_reset);

  property p_cov_thr_read;
    reg_req.rd && reg_req.addr == prox_regs_pkg::ADDR_THR_LO && threshold_val[15];
  endproperty
  c_cov_thr_read: cover property (p_cov_thr_read);

endmodule : prox_readback_reset_regs

// file: rtl/prox_regs_pkg.sv
// Purpose: shared register map, field widths and carrier types for the readback/reset bank
// Assumes: byte-wide register port driven by the serial host interface engine
// Notes:   addresses are register indices as seen by the host
package prox_regs_pkg;

  localparam int NUM_PHASES   = 4;
  localparam int PHASE_SEL_W  = 2;
  localparam int DATA_W       = 16;
  localparam int COMP_HI_W    = 6;
  localparam int OFFSET_W     = 14;

  localparam logic [7:0] ADDR_PHASE_SEL = 8'h60;
  localparam logic [7:0] ADDR_USE_HI    = 8'h61;
  localparam logic [7:0] ADDR_USE_LO    = 8'h62;
  localparam logic [7:0] ADDR_AVG_HI    = 8'h63;
  localparam logic [7:0] ADDR_AVG_LO    = 8'h64;
  localparam logic [7:0] ADDR_DIFF_HI   = 8'h65;
  localparam logic [7:0] ADDR_COMP_HI   = 8'h66;
  localparam logic [7:0] ADDR_COMP_LO   = 8'h68;
  localparam logic [7:0] ADDR_THR_HI    = 8'h69;
  localparam logic [7:0] ADDR_THR_LO    = 8'h6A;
  localparam logic [7:0] ADDR_SOFT_RST  = 8'h9F;
  localparam logic [7:0] ADDR_CHIP_ID   = 8'hFA;
  localparam logic [7:0] ADDR_REV       = 8'hFE;

  localparam logic [7:0] RESET_KEY      = 8'hDE;
  localparam logic [7:0] READ_ZERO      = 8'h00;
  localparam logic [1:0] COMP_HI_PAD    = 2'h0;
  localparam logic [PHASE_SEL_W-1:0] PHASE_SEL_RST = 2'h0;
  localparam logic [OFFSET_W-1:0]    OFFSET_RST    = 14'h0000;
  localparam logic [COMP_HI_W-1:0]   COMP_HI_RST   = 6'h00;
  localparam logic signed [DATA_W-1:0] THR_RST = 16'sh0000;
  localparam logic signed [DATA_W-1:0] THR_MAX = 16'sh7FFF;
  localparam logic signed [DATA_W-1:0] THR_MIN = -16'sh7FFF - 16'sh0001;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    logic [DATA_W-1:0] useful;
    logic [DATA_W-1:0] avg;
    logic [DATA_W-1:0] diff;
  } phase_data_t;

  function automatic logic [7:0] hi_byte(input logic [DATA_W-1:0] v);
    hi_byte = v[DATA_W-1:8];
  endfunction : hi_byte

  function automatic logic [7:0] lo_byte(input logic [DATA_W-1:0] v);
    lo_byte = v[7:0];
  endfunction : lo_byte

endpackage : prox_regs_pkg

// file: rtl/prox_threshold_calc.sv
// Purpose: detection threshold = slope * third phase sample + bias, signed, saturated
// Assumes: slope unsigned, sample and bias signed two's complement
// Notes:   one cycle of latency; result held in a flop
`timescale 1ns/1ps
module prox_threshold_calc
(
  input  wire logic                                      core_clk,
  input  wire logic                                      rst,
  input  wire logic [7:0]                                threshold_slope,
  input  wire logic signed [prox_regs_pkg::DATA_W-1:0]   third_phase_sample,
  input  wire logic signed [prox_regs_pkg::DATA_W-1:0]   threshold_bias,
  output logic signed [prox_regs_pkg::DATA_W-1:0]        threshold_reg
);

  logic signed [24:0] sum_full;
  logic signed [prox_regs_pkg::DATA_W-1:0] threshold_next;

  // wide enough for any slope*sample+bias, so saturation sees the true value
  assign sum_full = $signed({1'b0, threshold_slope}) * third_phase_sample
                  + threshold_bias;

  always_comb
  begin
    if (sum_full > 25'(prox_regs_pkg::THR_MAX))
      threshold_next = prox_regs_pkg::THR_MAX;
    else if (sum_full < 25'(prox_regs_pkg::THR_MIN))
      threshold_next = prox_regs_pkg::THR_MIN;
    else
      threshold_next = sum_full[prox_regs_pkg::DATA_W-1:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      threshold_reg <= prox_regs_pkg::THR_RST;
    else
      threshold_reg <= threshold_next;
  end

endmodule : prox_threshold_calc

// file: verif/host_model.sv
// Purpose: host side of the register port, one request per call
// Assumes: requests launched at the falling edge, sampled on rising core_clk
// Notes:   released lines show inverted values so stale data never looks valid
`timescale 1ns/1ps
module host_model
(
  input  wire logic                    core_clk,
  output prox_regs_pkg::reg_req_t      reg_req,
  input  wire prox_regs_pkg::reg_rsp_t reg_rsp_reg
);
  initial reg_req = '0;

  // high byte before low byte and the exact reset key are the caller's duty
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [8:0] rsp);
    @(negedge core_clk);
    reg_req = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
    @(negedge core_clk);
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
    rsp = {reg_rsp_reg.valid, reg_rsp_reg.rdata};
  endtask : access
endmodule : host_model

// file: verif/testbench.sv
// Purpose: self-checking bench for the readback and soft reset bank
// Assumes: inputs change at the falling edge; answers sampled one cycle after the request
// Notes:   offsets and threshold modelled with plain integers
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] PART = 8'h3C; // arbitrary value
  localparam logic [7:0] REV  = 8'h07; // arbitrary value
  logic                        core_clk = 1'b0;
  logic                        rst = 1'b1;
  prox_regs_pkg::reg_req_t     reg_req;
  prox_regs_pkg::reg_rsp_t     reg_rsp_reg;
  prox_regs_pkg::phase_data_t  phase_data [4];
  logic                        cal_valid = 1'b0;
  logic [1:0]                  cal_phase = 2'h0;
  logic [13:0]                 cal_offset = 14'h0000;
  logic [7:0]                  threshold_slope = 8'h00;
  logic signed [15:0]          third_phase_sample = 16'h0000;
  logic signed [15:0]          threshold_bias = 16'h0000;
  logic [13:0]                 comp_offset_reg [4];
  logic [1:0]                  readback_phase_select_reg;
  logic                        soft_reset_req_reg;
  int                          miscompares = 0;
  int                          total_checks = 0;
  int                          pulses = 0;
  int                          off_q [4];
  logic [31:0]                 lfsr = 32'he793;
  logic [8:0]                  rsp;
  logic [15:0]                 e;
  logic [7:0]                  zero_addr [6] = '{8'h60, 8'h66, 8'h68, 8'h69, 8'h6A, 8'h9F};

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) pulses += int'(soft_reset_req_reg);

  host_model host_model_inst (.core_clk(core_clk), .reg_req(reg_req), .reg_rsp_reg(reg_rsp_reg));

  prox_readback_reset_regs #(.PHASES(4), .PART_CODE(PART), .REVISION_CODE(REV))
  prox_readback_reset_regs_inst (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .reg_rsp_reg(reg_rsp_reg), .phase_data(phase_data), .cal_valid(cal_valid),
    .cal_phase(cal_phase), .cal_offset(cal_offset), .threshold_slope(threshold_slope),
    .third_phase_sample(third_phase_sample), .threshold_bias(threshold_bias),
    .comp_offset_reg(comp_offset_reg), .readback_phase_select_reg(readback_phase_select_reg),
    .soft_reset_req_reg(soft_reset_req_reg));

  function automatic logic [31:0] nxt(input logic [31:0] v);
    nxt = {v[30:0], ^(v & 32'h8020_0003)};
  endfunction : nxt

  // saturating, as the bank clamps rather than wraps
  function automatic logic [15:0] thr(input int s, input int x, input int b);
    int t;
    t = s * x + b;
    if (t > 32767)
      t = 32767;
    if (t < -32768)
      t = -32768;
    thr = t[15:0];
  endfunction : thr

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_model_inst.access(1'b1, a, d, rsp);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_model_inst.access(1'b0, a, 8'h00, rsp);
    check({7'h00, rsp}, {8'h01, exp}, "read");
  endtask : rd_chk

  task automatic offsets_chk();
    for (int p = 0; p < 4; p++)
      check({2'h0, comp_offset_reg[p]}, off_q[p][15:0], "offset");
  endtask : offsets_chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  initial
  begin
    #(4 * 20000);
    miscompares++;
    summarize();
  end

  initial
  begin
    logic [7:0] h;
    logic [7:0] l;
    for (int p = 0; p < 4; p++)
      phase_data[p] = '0;
    off_q = '{0, 0, 0, 0};
    repeat (8) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    foreach (zero_addr[i])
      rd_chk(zero_addr[i], 8'h00);
    wr(8'hFA, 8'hFF);
    wr(8'hFE, 8'h00);
    rd_chk(8'hFA, PART);
    rd_chk(8'hFE, REV);
    for (int p = 0; p < 4; p++)
    begin
      lfsr = nxt(lfsr);
      phase_data[p] = {lfsr[15:0], lfsr[31:16], lfsr[23:8]};
      wr(8'h60, 8'(p));
      check({14'h0000, readback_phase_select_reg}, 16'(p), "select");
      rd_chk(8'h61, lfsr[15:8]);
      rd_chk(8'h62, lfsr[7:0]);
      rd_chk(8'h63, lfsr[31:24]);
      rd_chk(8'h64, lfsr[23:16]);
      rd_chk(8'h65, lfsr[23:16]);
      h = lfsr[7:0];
      l = lfsr[15:8];
      wr(8'h66, h);
      offsets_chk();
      wr(8'h68, l);
      off_q[p] = {h[5:0], l};
      offsets_chk();
      rd_chk(8'h66, {2'h0, h[5:0]});
      rd_chk(8'h68, l);
      wr(8'h68, ~l);
      off_q[p] = {h[5:0], ~l};
      offsets_chk();
    end
    @(negedge core_clk);
    cal_valid = 1'b1;
    cal_phase = 2'h2;
    cal_offset = lfsr[29:16];
    @(negedge core_clk);
    cal_valid = 1'b0;
    off_q[2] = lfsr[29:16];
    offsets_chk();
    for (int i = 0; i < 8; i++)
    begin
      lfsr = nxt(lfsr);
      @(negedge core_clk);
      threshold_slope = (i < 2) ? 8'hFF : lfsr[7:0];
      third_phase_sample = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 : lfsr[23:8];
      threshold_bias = (i < 2) ? third_phase_sample : {{4{lfsr[31]}}, lfsr[31:20]};
      e = thr(int'(threshold_slope), int'(third_phase_sample), int'(threshold_bias));
      rd_chk(8'h69, e[15:8]);
      rd_chk(8'h6A, e[7:0]);
    end
    wr(8'h9F, 8'hDF);
    repeat (3) @(negedge core_clk);
    check(16'(pulses), 16'h0000, "no reset");
    offsets_chk();
    // pending upper byte left open so the reset must drop it
    wr(8'h66, 8'h3F);
    wr(8'h9F, 8'hDE);
    repeat (3) @(negedge core_clk);
    check(16'(pulses), 16'h0001, "reset pulse");
    off_q = '{0, 0, 0, 0};
    offsets_chk();
    rd_chk(8'h60, 8'h00);
    rd_chk(8'h9F, 8'h00);
    wr(8'h68, 8'hA5);
    off_q[0] = 32'h0000_00A5;
    offsets_chk();
    rd_chk(8'h69, e[15:8]);
    summarize();
  end
endmodule : testbench
